// *** audio_dac_cfg.svh ***
// Constants of the audio output converter datapath
`ifndef AUDIO_DAC_CFG_SVH
`define AUDIO_DAC_CFG_SVH

// 128 fs tick divider; default suits fs = 44.1 kHz from a 125 MHz sys_clk
`define CLK_PER_TICK 22
`define PHASE_W 7
`define PH_HALF 7'h40

// Half-band stage: 99 taps, of which the centre and 50 odd taps are nonzero
`define HALFBAND_HALF 25
`define HALFBAND_LEN 50
`define HALFBAND_CENTER 25
`define HALFBAND_PEAK 20861

// Four-phase FIR stage: 31 taps, symmetric, indexed by distance from centre
`define FIR_LEN 8
`define FIR_MAXD 15
`define FIR_SPAN 16
`define FIR_PHASES 4
`define FIR_SLOT 4'h8
`define COEF_W 18
`define COEF_FRAC 15
`define FIR_COEFS {18'h3f851, 18'h3f45c, 18'h3f723, 18'h00000, 18'h00a7a, 18'h0104c, \
  18'h00cce, 18'h00000, 18'h3ef8a, 18'h3e4d6, 18'h3e8f3, 18'h00000, 18'h0266a, \
  18'h0517d, 18'h0733d, 18'h08000}

// Quantiser and tap decoder
`define TAPS 15
`define CODE_MAX 12
`define CODE_MID 6
`define TAP_OFFSET 1

`define FIFO_DEPTH 8

`endif

// *** audio_dac_pkg.sv ***
// Shared types of the audio output converter datapath
`include "audio_dac_cfg.svh"
package audio_dac_pkg;
  typedef logic [3:0] code_t;
  typedef logic [`TAPS-1:0] tap_t;
  typedef logic [3:0] ptr_t;
  typedef logic [`PHASE_W-1:0] phase_t;
  typedef logic signed [`COEF_W-1:0] coef_t;
endpackage

// *** audio_output_converter.sv ***
// Interpolator, noise shaper and tap decoder for six audio output channels
`timescale 1ns/100ps
`include "audio_dac_cfg.svh"
module audio_output_converter #(
  parameter int CH = 6,
  parameter int SW = 24,
  parameter int DIV = `CLK_PER_TICK,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic smp_valid,
  output logic smp_ready,
  input wire logic [CH*SW-1:0] smp_data,
  output logic fs_tick,
  output logic os_tick,
  output logic underrun,
  output logic [CH-1:0][`TAPS-1:0] tap_to_ref_high,
  output logic [CH-1:0][3:0] shaper_code
);
  // DIV must be at least 2
  localparam int ACW = SW + `COEF_W + 7;
  localparam int NW = SW + 6;
  localparam int QS = SW - 3;
  localparam int DIVW = $clog2(DIV);
  localparam logic signed [ACW-1:0] SMAX = ACW'(2 ** (SW - 1) - 1);
  localparam logic signed [ACW-1:0] SMIN = -SMAX - ACW'(1);
  localparam logic signed [NW-1:0] HALF = NW'(2 ** (QS - 1));
  localparam logic signed [NW-1:0] STEP = NW'(2 ** QS);
  localparam logic signed [NW-1:0] QLIM = NW'(`CODE_MID);

  typedef logic signed [SW-1:0] smp_t;
  typedef logic signed [NW-1:0] nsw_t;

  typedef struct packed {
    smp_t [`HALFBAND_LEN-1:0] halfband_hist;
    smp_t y2;
    smp_t [`FIR_LEN-1:0] x2;
    smp_t y8;
    smp_t y8p;
    smp_t y16;
    nsw_t e1;
    nsw_t e2;
    nsw_t e3;
    audio_dac_pkg::code_t code;
    audio_dac_pkg::ptr_t ptr;
    audio_dac_pkg::tap_t taps;
  } chan_s;

  typedef struct packed {
    logic [DIVW-1:0] div;
    logic tick;
    audio_dac_pkg::phase_t phase;
    logic unf;
    logic [CH*SW-1:0] smp;
    chan_s [CH-1:0] ch;
  } core_s;

  core_s s_r;
  core_s s_nxt;
  logic fs_slot;

  sample_stream_if #(.W(CH*SW)) push_if ();
  sample_stream_if #(.W(CH*SW)) pop_if ();

  assign push_if.valid = smp_valid;
  assign push_if.data = smp_data;
  assign smp_ready = push_if.ready;

  sample_fifo #(
    .W(CH*SW),
    .DEPTH(DEPTH)
  ) in_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .wr(push_if),
    .rd(pop_if)
  );

  // One sample set is taken per 1 fs slot; a missing one repeats the last set
  assign fs_slot = s_r.tick && (s_r.phase == '0);
  assign pop_if.ready = fs_slot;
  assign fs_tick = fs_slot;
  assign os_tick = s_r.tick;
  assign underrun = s_r.unf;

  // Truncated sinc weights; alternating sign, odd taps only
  function automatic audio_dac_pkg::coef_t halfband_coef(input int m);
    int mag;
    mag = `HALFBAND_PEAK / (2 * m + 1);
    return audio_dac_pkg::coef_t'((m % 2 == 1) ? -mag : mag);
  endfunction

  function automatic audio_dac_pkg::coef_t fir_coef(input int d);
    logic [(`FIR_MAXD+1)*`COEF_W-1:0] tab;
    int a;
    tab = `FIR_COEFS;
    a = (d < 0) ? -d : d;
    if (a > `FIR_MAXD)
      return '0;
    return tab[a*`COEF_W +: `COEF_W];
  endfunction

  function automatic smp_t sat(input logic signed [ACW-1:0] a);
    if (a > SMAX)
      return SW'(SMAX);
    if (a < SMIN)
      return SW'(SMIN);
    return SW'(a);
  endfunction

  function automatic audio_dac_pkg::tap_t therm_rot(input logic [3:0] n,
                                                    input audio_dac_pkg::ptr_t p);
    logic [2*`TAPS-1:0] dbl;
    audio_dac_pkg::tap_t mask;
    mask = audio_dac_pkg::tap_t'((16'h0001 << n) - 16'h0001);
    dbl = {mask, mask} << p;
    return dbl[2*`TAPS-1:`TAPS];
  endfunction

  always_comb
  begin
    logic signed [ACW-1:0] acc;
    logic signed [SW:0] mid;
    smp_t xin;
    nsw_t u;
    nsw_t v;
    nsw_t q;
    nsw_t e;
    logic [3:0] n;
    logic [4:0] pn;
    acc = '0;
    mid = '0;
    xin = '0;
    u = '0;
    v = '0;
    q = '0;
    e = '0;
    n = '0;
    pn = '0;
    s_nxt = s_r;
    s_nxt.unf = 1'b0;
    s_nxt.tick = (s_r.div == DIVW'(DIV - 1));
    s_nxt.div = s_nxt.tick ? '0 : s_r.div + 1'b1;
    // Phase 0..127 within one fs period; the half-band, FIR and linear stages key off its bits, the shaper runs every tick
    if (s_r.tick)
      s_nxt.phase = s_r.phase + 1'b1;
    if (fs_slot)
    begin
      if (pop_if.valid)
        s_nxt.smp = pop_if.data;
      else
        s_nxt.unf = 1'b1;
    end
    for (int c = 0; c < CH; c++)
    begin
      if (fs_slot)
      begin
        xin = smp_t'(s_nxt.smp[c*SW +: SW]);
        s_nxt.ch[c].halfband_hist = {s_r.ch[c].halfband_hist[`HALFBAND_LEN-2:0], xin};
      end
      if (s_r.tick)
      begin
        if (s_r.phase[5:0] == '0)
        begin
          s_nxt.ch[c].x2 = {s_r.ch[c].x2[`FIR_LEN-2:0], s_r.ch[c].y2};
          if (s_r.phase[6])
            s_nxt.ch[c].y2 = s_r.ch[c].halfband_hist[`HALFBAND_CENTER];
          else
          begin
            // Midpoint between the two centre samples, taken before the shift
            acc = '0;
            for (int m = 0; m < `HALFBAND_HALF; m++)
              acc = acc + ACW'(halfband_coef(m))
                * ACW'($signed(s_r.ch[c].halfband_hist[`HALFBAND_CENTER-1-m])
                + $signed(s_r.ch[c].halfband_hist[`HALFBAND_CENTER+m]));
            s_nxt.ch[c].y2 = sat(acc >>> `COEF_FRAC);
          end
        end
        if (s_r.phase[3:0] == `FIR_SLOT)
        begin
          // Mid-slot so the 2 fs history is settled for all four phases
          acc = '0;
          for (int j = 0; j < `FIR_LEN; j++)
            acc = acc + ACW'(fir_coef(`FIR_SPAN - `FIR_PHASES * j - int'(s_r.phase[5:4])))
              * ACW'($signed(s_r.ch[c].x2[j]));
          s_nxt.ch[c].y8p = s_r.ch[c].y8;
          s_nxt.ch[c].y8 = sat(acc >>> `COEF_FRAC);
          s_nxt.ch[c].y16 = s_r.ch[c].y8;
        end
        else if (s_r.phase[3:0] == '0)
        begin
          mid = (SW + 1)'($signed(s_r.ch[c].y8)) + (SW + 1)'($signed(s_r.ch[c].y8p));
          s_nxt.ch[c].y16 = smp_t'(mid >>> 1);
        end
        // y16 is left alone on the other fourteen ticks, so it repeats eight times
        n = s_r.ch[c].code + 4'(`TAP_OFFSET);
        s_nxt.ch[c].taps = therm_rot(n, s_r.ch[c].ptr);
        pn = 5'(s_r.ch[c].ptr) + 5'(n);
        s_nxt.ch[c].ptr = 4'((pn >= 5'(`TAPS)) ? pn - 5'(`TAPS) : pn);
        // Half-scale input keeps the loop inside the code range; costs 6 dB of swing
        u = nsw_t'(s_r.ch[c].y16 >>> 1);
        v = u - (s_r.ch[c].e1 <<< 1) - s_r.ch[c].e1 + (s_r.ch[c].e2 <<< 1)
          + s_r.ch[c].e2 - s_r.ch[c].e3;
        q = (v + HALF) >>> QS;
        if (q > QLIM)
          q = QLIM;
        else if (q < -QLIM)
          q = -QLIM;
        // Error is bounded so an overload cannot wind the loop up without limit
        e = (q <<< QS) - v;
        if (e > STEP)
          e = STEP;
        else if (e < -STEP)
          e = -STEP;
        s_nxt.ch[c].e3 = s_r.ch[c].e2;
        s_nxt.ch[c].e2 = s_r.ch[c].e1;
        s_nxt.ch[c].e1 = e;
        s_nxt.ch[c].code = 4'(q + QLIM);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // Tap bit high selects the high reference, low selects the low reference
  for (genvar c = 0; c < CH; c++)
  begin : g_out
    assign tap_to_ref_high[c] = s_r.ch[c].taps;
    assign shaper_code[c] = s_r.ch[c].code;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  chk_fs_spacing: assert property (
    fs_tick |=> (!fs_tick) [*8])
    else $error("Two fs slots too close together");

  chk_halfband_center: assert property (
    s_r.tick && s_r.phase == `PH_HALF
      |=> s_r.ch[0].y2 == $past(s_r.ch[0].halfband_hist[`HALFBAND_CENTER]))
    else $error("Half-band even output is not the centre sample");

  chk_fir_slot: assert property (
    !(s_r.tick && s_r.phase[3:0] == `FIR_SLOT) |=> $stable(s_r.ch[0].y8))
    else $error("FIR output changed outside its 8 fs slot");

  chk_lin_pass: assert property (
    s_r.tick && s_r.phase[3:0] == `FIR_SLOT |=> s_r.ch[0].y16 == $past(s_r.ch[0].y8))
    else $error("Interpolator did not pass the stored 8 fs sample");

  chk_hold_repeat: assert property (
    !(s_r.tick && s_r.phase[2:0] == 3'h0) |=> $stable(s_r.ch[0].y16))
    else $error("Held sample changed between 16 fs slots");

  chk_ns_update: assert property (
    !s_r.tick |=> $stable(s_r.ch[0].code) && $stable(s_r.ch[0].e1))
    else $error("Noise shaper moved without a 128 fs tick");

  chk_code_span: assert property (
    s_r.tick |=> s_r.ch[CH-1].code <= 4'(`CODE_MAX))
    else $error("Shaper code above the top level");

  chk_therm_count: assert property (
    s_r.tick |=> $countones(s_r.ch[0].taps) == int'($past(s_r.ch[0].code)) + `TAP_OFFSET)
    else $error("Tap count does not match the code");

  chk_ptr_range: assert property (
    s_r.ch[0].ptr < 4'(`TAPS))
    else $error("Rotation pointer outside the tap range");

  chk_ptr_step: assert property (
    s_r.tick |=> int'(s_r.ch[0].ptr) == (int'($past(s_r.ch[0].ptr))
      + int'($past(s_r.ch[0].code)) + `TAP_OFFSET) % `TAPS)
    else $error("Rotation pointer advanced by the wrong amount");

  cov_underrun: cover property (underrun);
  cov_top_code: cover property (s_r.ch[0].code == 4'(`CODE_MAX));
  cov_ptr_wrap: cover property (s_r.tick ##1 s_r.ch[0].ptr < $past(s_r.ch[0].ptr));
  cov_fs_taken: cover property (fs_tick && pop_if.valid);
endmodule

// *** audio_output_converter_tb.sv ***
// Self-checking bench for the audio output converter
`timescale 1ns/100ps
`include "audio_dac_cfg.svh"
module audio_output_converter_tb;
  localparam int CH = 6;
  localparam int DIV = 3;
  localparam int DEPTH = 8;
  logic sys_clk, smp_valid, smp_ready, fs_tick, os_tick, underrun, exp_ur;
  logic rst_b = 1'b0;
  logic en = 1'b0;
  logic mon_on = 1'b0;
  logic acc_on = 1'b0;
  logic first = 1'b1;
  logic [CH*24-1:0] smp_data;
  logic [CH-1:0][`TAPS-1:0] taps;
  logic [CH-1:0][3:0] code;
  logic [CH*`TAPS-1:0] nxt;
  logic [CH*`TAPS-1:0] exp_q[$];
  int accepted, k;
  int fail_count = 0, tests_run = 0, pops = 0, cyc = 0, os_cnt = 0, ur_cnt = 0;
  int os_seen = 0, fs_seen = 0;
  int ptr[CH];
  int sum[CH];

  audio_output_converter #(.CH(CH), .SW(24), .DIV(DIV), .DEPTH(DEPTH)) i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .smp_data(smp_data), .fs_tick(fs_tick), .os_tick(os_tick), .underrun(underrun),
    .tap_to_ref_high(taps), .shaper_code(code));
  audio_source_model #(.CH(CH), .SW(24)) i_src (
    .sys_clk(sys_clk), .rst_b(rst_b), .en(en), .smp_ready(smp_ready),
    .smp_valid(smp_valid), .smp_data(smp_data), .accepted(accepted));

  task chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task end_sim();
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task wait_fs(input int n);
    int j;
    j = 0;
    while (n > 0 && j < 40000)
    begin
      @(negedge sys_clk);
      j++;
      if (fs_tick === 1'b1)
        n--;
    end
    if (n > 0)
    begin
      fail_count++;
      end_sim();
    end
  endtask

  function automatic logic [`TAPS-1:0] rot(input logic [3:0] cd, input int p);
    logic [2*`TAPS-1:0] w;
    w = ((2*`TAPS)'(1) << (cd + 1)) - 1;
    w = w << p;
    return w[`TAPS-1:0] | w[2*`TAPS-1:`TAPS];
  endfunction

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Tick spacing and underrun bookkeeping against the bench's own occupancy count
  always @(negedge sys_clk)
    if (mon_on)
    begin
      cyc++;
      if (os_tick === 1'b1)
      begin
        os_cnt++;
        if (os_seen) chk("os_gap", cyc, DIV);
        os_seen = 1;
        cyc = 0;
      end
      if (fs_tick === 1'b1)
      begin
        chk("fs_with_os", os_tick, 1'b1);
        if (fs_seen)
        begin
          chk("fs_gap", os_cnt, 128);
          chk("underrun", ur_cnt, exp_ur);
        end
        fs_seen = 1;
        os_cnt = 0;
        ur_cnt = 0;
        exp_ur = (accepted == pops);
        if (!exp_ur) pops++;
      end
      if (underrun === 1'b1) ur_cnt++;
    end

  // Watcher: compares the taps seen at each tick with the oldest note
  always @(negedge sys_clk)
    if (mon_on && os_tick === 1'b1 && exp_q.size() > 0)
      chk("taps", taps, exp_q.pop_front());

  // Noter: runs after the watcher so the note for the next tick is queued behind it
  always @(negedge sys_clk)
    if (mon_on && os_tick === 1'b1)
    begin
      #2;
      for (int c = 0; c < CH; c++)
      begin
        chk("code_range", code[c] <= 4'hc, 1'b1);
        if (first) ptr[c] = 0;
        nxt[c*`TAPS +: `TAPS] = rot(code[c], ptr[c]);
        ptr[c] = (ptr[c] + code[c] + 1) % `TAPS;
        if (acc_on) sum[c] += code[c];
      end
      first = 1'b0;
      exp_q.push_back(nxt);
    end

  initial
  begin
    for (int c = 0; c < CH; c++) sum[c] = 0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("rst_ready", smp_ready, 1'b1);
    chk("rst_out", {fs_tick, os_tick, underrun, taps, code}, 0);
    rst_b <= 1'b1;
    mon_on <= 1'b1;
    wait_fs(1);
    en <= 1'b1;
    for (k = 0; k < 100 && smp_ready !== 1'b0; k++) @(negedge sys_clk);
    if (k == 100)
    begin
      fail_count++;
      end_sim();
    end
    chk("fill", accepted - pops, DEPTH + 1);
    en <= 1'b0;
    wait_fs(13);
    en <= 1'b1;
    // The half-band history must fill with the steady input before the levels are summed
    wait_fs(60);
    acc_on = 1'b1;
    wait_fs(4);
    acc_on = 1'b0;
    chk("dc_pos", sum[0] > sum[2], 1'b1);
    chk("dc_neg", sum[2] > sum[1], 1'b1);
    end_sim();
  end
endmodule

// *** audio_source_model.sv ***
// Sample source model standing in for the audio processor
`timescale 1ns/100ps
module audio_source_model #(
  parameter int CH = 6,
  parameter int SW = 24
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic en,
  input wire logic smp_ready,
  output logic smp_valid,
  output logic [CH*SW-1:0] smp_data,
  output int accepted
);
  logic [31:0] seed = 32'h11084095;
  logic taken = 1'b0;
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  initial
  begin
    smp_valid = 1'b0;
    smp_data = '0;
    accepted = 0;
  end
  always @(posedge sys_clk)
  begin
    taken <= smp_valid && smp_ready;
    if (smp_valid && smp_ready)
      accepted <= accepted + 1;
  end
  // An offer is never withdrawn before it is taken; idle data toggles so no stale copy shows
  always @(negedge sys_clk)
  begin
    if (!smp_valid || taken)
    begin
      smp_valid <= en && rst_b;
      if (en && rst_b)
      begin
        smp_data[SW-1:0] <= {2'b01, {(SW-2){1'b0}}};
        smp_data[SW +: SW] <= {2'b11, {(SW-2){1'b0}}};
        smp_data[2*SW +: SW] <= '0;
        for (int c = 3; c < CH; c++)
        begin
          seed = xorshift(seed);
          smp_data[c*SW +: SW] <= SW'(seed);
        end
      end
      else
        smp_data <= ~smp_data;
    end
  end
endmodule

// *** sample_fifo.sv ***
// Parameterised sample FIFO with a registered read stage
`timescale 1ns/100ps
`include "audio_dac_cfg.svh"
module sample_fifo #(
  parameter int W = 144,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  sample_stream_if.snk wr,
  sample_stream_if.src rd
);
  // DEPTH must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic out_v;
    logic [W-1:0] out_d;
  } fifo_s;

  fifo_s s_r;
  fifo_s s_nxt;
  logic push;
  logic pop_mem;

  assign wr.ready = (s_r.cnt != (AW + 1)'(DEPTH));
  assign push = wr.valid && wr.ready;
  // Refill the output register when it is empty or being drained
  assign pop_mem = (s_r.cnt != '0) && (!s_r.out_v || rd.ready);
  assign rd.valid = s_r.out_v;
  assign rd.data = s_r.out_d;

  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = wr.data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (s_r.out_v && rd.ready)
      s_nxt.out_v = 1'b0;
    if (pop_mem)
    begin
      s_nxt.out_d = s_r.mem[s_r.rp];
      s_nxt.out_v = 1'b1;
      s_nxt.rp = s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop_mem);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  chk_refused_push: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr.valid && !wr.ready |=> s_r.cnt <= $past(s_r.cnt))
    else $error("FIFO grew while refusing a push");

  chk_out_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd.valid && !rd.ready |=> rd.valid && $stable(rd.data))
    else $error("FIFO output changed while stalled");

  cov_fifo_full: cover property (@(posedge sys_clk) disable iff (!rst_b)
    !wr.ready);
endmodule

// *** sample_stream_if.sv ***
// Valid/ready sample stream between the converter core and its buffer
`timescale 1ns/100ps
interface sample_stream_if #(parameter int W = 144);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
